// File: design/sstd_pkg.sv
/*
 * Shared constants and carrier types for the supervisor state and
 * countdown block. Assumes MSB-0 bit numbering in software maps to
 * LSB index 31-n in the hardware vectors.
 */
package sstd_pkg;

    // ------------------------------------------------------------
    // Special register numbers
    // ------------------------------------------------------------
    localparam logic [9:0] SPR_FLT_RSN = 10'h012;
    localparam logic [9:0] SPR_FLT_ADR = 10'h013;
    localparam logic [9:0] SPR_CDOWN   = 10'h016;
    localparam logic [9:0] SPR_RET_ADR = 10'h01a;
    localparam logic [9:0] SPR_SAVED   = 10'h01b;
    localparam logic [9:0] SPR_TICK_LR = 10'h10c;
    localparam logic [9:0] SPR_TICK_HR = 10'h10d;
    localparam logic [9:0] SPR_TICK_LW = 10'h11c;
    localparam logic [9:0] SPR_TICK_HW = 10'h11d;

    // ------------------------------------------------------------
    // Machine state word bit positions (LSB index)
    // ------------------------------------------------------------
    localparam int B_ORDER_TRAP = 16;
    localparam int B_EXT_IRQ    = 15;
    localparam int B_USER_ONLY  = 14;
    localparam int B_FLOAT_ON   = 13;
    localparam int B_MCHECK_ON  = 12;
    localparam int B_FTRAP0     = 11;
    localparam int B_STEP_TRACE = 10;
    localparam int B_BR_TRACE   = 9;
    localparam int B_FTRAP1     = 8;
    localparam int B_VEC_HIGH   = 6;
    localparam int B_CAN_RESUME = 1;
    localparam int B_ORDER_NORM = 0;

    localparam logic [31:0] MSW_WR_MASK = 32'h0001_ff43;
    localparam logic [31:0] MSW_RESET   = 32'h0000_0000;
    // Bits cleared on entry to a handler: irq, user, float, float trap mode, traces, RI.
    localparam logic [31:0] MSW_EXC_CLR = 32'h0000_ef03;
    localparam logic [31:0] VEC_BASE_LO = 32'h0000_0000;
    localparam logic [31:0] VEC_BASE_HI = 32'hfff0_0000;
    localparam logic [31:0] CDOWN_RESET = 32'h0000_0000;
    localparam logic [63:0] TICK_RESET  = 64'h0000_0000_0000_0000;

    // Countdown clock divider ratio.
    localparam int CDOWN_DIV = 16;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] info;
        logic [31:0] resume;
    } sstd_exc_t;

    typedef struct packed {
        logic        user_only_mode;
        logic        float_unit_on;
        logic        machine_check_on;
        logic        step_trace_on;
        logic        branch_trace_on;
        logic        float_precise;
        logic        little_endian;
        logic [31:0] vector_base;
    } sstd_ctl_t;

endpackage

// File: design/sstd_msw_decode.sv
/*
 * Decodes the machine state word into the control view used by the
 * pipeline. Assumes the word comes from a register on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module sstd_msw_decode
(
    // State word in
    input  wire logic [31:0]       i_msw,
    // Decoded control out
    output sstd_pkg::sstd_ctl_t    o_ctl
);
    import sstd_pkg::*;

    always_comb
    begin
        o_ctl.user_only_mode   = i_msw[B_USER_ONLY];
        o_ctl.float_unit_on    = i_msw[B_FLOAT_ON];
        o_ctl.machine_check_on = i_msw[B_MCHECK_ON];
        o_ctl.step_trace_on    = i_msw[B_STEP_TRACE];
        o_ctl.branch_trace_on  = i_msw[B_BR_TRACE];
        o_ctl.float_precise    = i_msw[B_FTRAP0] | i_msw[B_FTRAP1];
        o_ctl.little_endian    = i_msw[B_ORDER_NORM];
        o_ctl.vector_base      = i_msw[B_VEC_HIGH] ? VEC_BASE_HI : VEC_BASE_LO;
    end

endmodule
`default_nettype wire

// File: design/sstd_tick_count.sv
/*
 * The 64-bit tick counter and the 32-bit countdown register with its
 * request latch. Assumes write strobes are already privilege-checked.
 */
`timescale 1ns/10ps
`default_nettype none

module sstd_tick_count
#(
    parameter int DIV = sstd_pkg::CDOWN_DIV
)
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // Writes
    input  wire logic        i_wr_lo,
    input  wire logic        i_wr_hi,
    input  wire logic        i_wr_cd,
    input  wire logic [31:0] i_wdata,
    // Countdown exception taken
    input  wire logic        i_cd_taken,
    // State
    output logic      [63:0] o_tick,
    output logic      [31:0] o_cdown,
    output logic             o_cd_pend
);
    import sstd_pkg::*;

    logic [$clog2(DIV)-1:0] div_q;
    logic                   tick_en;
    logic [63:0]            tick_q;
    logic [31:0]            cd_q;
    logic [31:0]            cd_d;
    logic                   pend_q;

    // --------------------------------------------------------------
    // Rate divider
    // --------------------------------------------------------------
    assign tick_en = (div_q == ($clog2(DIV))'(DIV - 1));

    always_ff @(posedge i_clock)
    begin
        if (i_srst || tick_en)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    // --------------------------------------------------------------
    // Tick counter, halves written independently
    // --------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            tick_q <= TICK_RESET;
        else if (i_wr_lo)
            tick_q[31:0] <= i_wdata;
        else if (i_wr_hi)
            tick_q[63:32] <= i_wdata;
        else if (tick_en)
            tick_q <= tick_q + 64'h1;
    end

    // --------------------------------------------------------------
    // Countdown
    // --------------------------------------------------------------
    always_comb
    begin
        if (i_wr_cd)
            cd_d = i_wdata;
        else if (tick_en)
            cd_d = cd_q - 32'h1;
        else
            cd_d = cd_q;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            cd_q <= CDOWN_RESET;
        else
            cd_q <= cd_d;
    end

    // A new crossing in the cycle of the take still stands pending.
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            pend_q <= 1'b0;
        else if (!cd_q[31] && cd_d[31])
            pend_q <= 1'b1;
        else if (i_cd_taken)
            pend_q <= 1'b0;
    end

    assign o_tick    = tick_q;
    assign o_cdown   = cd_q;
    assign o_cd_pend = pend_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    a_cd_edge_pend:
        assert property (@(posedge i_clock) disable iff (i_srst)
            (!cd_q[31] && cd_d[31]) |=> pend_q)
        else $error("countdown crossing did not raise a request");

    a_cd_write_load:
        assert property (@(posedge i_clock) disable iff (i_srst)
            i_wr_cd |=> (cd_q == $past(i_wdata)))
        else $error("countdown write not loaded");

    a_tick_half_keep:
        assert property (@(posedge i_clock) disable iff (i_srst)
            i_wr_lo |=> (tick_q[63:32] == $past(tick_q[63:32])))
        else $error("low half write disturbed high half");

endmodule
`default_nettype wire

// File: design/sstd_supervisor_top.sv
/*
 * Supervisor state logic: machine state word, fault reason and address,
 * save/restore pair, and the special register move port in front of the
 * tick and countdown counters. Assumes the pipeline presents one move,
 * exception take or return per cycle at most, on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Exception copies trap byte order to normal.
// - Interrupt enable clear holds off external, countdown.
// - User-only bit blocks supervisor instructions.
// - Float off refuses float instruction dispatch.
// - Machine checks taken only when enabled.
// - Step trace after next clean instruction.
// - Branch trace on each completed branch.
// - Vector base chosen by high-pick bit.
// - Resume bit marks recoverable machine state.
// - Normal byte order from its bit.
// - Nonzero float trap mode means precise.
// - Fault reason recorded, untouched by reset.
// - Alignment fault loads fault address.
// - Tick counter writes need supervisor level.
// - Tick halves written independently.
// - Countdown decrements on divided clock, requests.
// - Reading countdown changes nothing.
// - Countdown write overwrites count.
// - Bit zero rising raises countdown request.
// - Taking countdown exception drops pending ones.
// - Exception loads resume address.
// - Exception saves info and low state half.
// - Exception saves state, then updates it.
module sstd_supervisor_top
#(
    parameter int CD_DIV = sstd_pkg::CDOWN_DIV
)
(
    // Clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_srst,
    input  wire logic                 i_vec_strap,

    // Special register move port
    input  wire logic                 i_spr_wr,
    input  wire logic                 i_spr_rd,
    input  wire logic [9:0]           i_spr_num,
    input  wire logic [31:0]          i_spr_wdata,
    output logic      [31:0]          o_spr_rdata,
    output logic                      o_spr_refused,

    // State word move port
    input  wire logic                 i_msw_wr,
    input  wire logic [31:0]          i_msw_wdata,
    output logic      [31:0]          o_msw,

    // Exception entry and return
    input  wire logic                 i_exc_take,
    input  wire sstd_pkg::sstd_exc_t  i_exc,
    input  wire logic                 i_exc_is_cd,
    input  wire logic                 i_rfi,
    output logic      [31:0]          o_resume_pc,

    // Alignment and data access faults
    input  wire logic                 i_align_fault,
    input  wire logic                 i_data_fault,
    input  wire logic [31:0]          i_fault_reason,
    input  wire logic [31:0]          i_fault_addr,

    // Pipeline events
    input  wire logic                 i_ext_irq,
    input  wire logic                 i_mcheck,
    input  wire logic                 i_instr_done,
    input  wire logic                 i_instr_exc,
    input  wire logic                 i_branch_done,
    input  wire logic                 i_fp_instr,
    input  wire logic                 i_sup_instr,

    // Decoded control and requests
    output sstd_pkg::sstd_ctl_t       o_ctl,
    output logic                      o_ext_req,
    output logic                      o_cd_req,
    output logic                      o_mcheck_req,
    output logic                      o_trace_req,
    output logic                      o_fp_refuse,
    output logic                      o_priv_refuse,
    output logic                      o_recoverable
);
    import sstd_pkg::*;

    // --------------------------------------------------------------
    // Move port decode
    // --------------------------------------------------------------

    function automatic logic spr_mapped(input logic [9:0] num, input logic wr);
        logic ok;
        ok = 1'b0;
        case (num)
            SPR_FLT_RSN, SPR_FLT_ADR, SPR_CDOWN, SPR_RET_ADR, SPR_SAVED:
                ok = 1'b1;
            SPR_TICK_LR, SPR_TICK_HR:
                ok = !wr;
            SPR_TICK_LW, SPR_TICK_HW:
                ok = wr;
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Only the tick read numbers are open to user-level code.
    function automatic logic spr_user_ok(input logic [9:0] num);
        return (num == SPR_TICK_LR) || (num == SPR_TICK_HR);
    endfunction

    logic [31:0] msw_q;
    logic [31:0] ret_adr_q;
    logic [31:0] saved_q;
    logic [31:0] flt_rsn_q;
    logic [31:0] flt_adr_q;
    logic [31:0] rdata_q;
    logic        refused;
    logic        wr_ok;
    logic        rd_ok;
    logic [63:0] tick;
    logic [31:0] cdown;
    logic        cd_pend;
    logic        user_mode;

    assign user_mode = msw_q[B_USER_ONLY];

    // Unmapped numbers and supervisor numbers from user level are refused.
    always_comb
    begin
        refused = 1'b0;
        if (i_spr_wr || i_spr_rd)
        begin
            if (!spr_mapped(i_spr_num, i_spr_wr))
                refused = 1'b1;
            else if (user_mode && !spr_user_ok(i_spr_num))
                refused = 1'b1;
        end
    end

    assign wr_ok         = i_spr_wr && !refused;
    assign rd_ok         = i_spr_rd && !refused;
    assign o_spr_refused = refused;

    // --------------------------------------------------------------
    // Counters
    // --------------------------------------------------------------

    sstd_tick_count
    #(
        .DIV        (CD_DIV)
    )
    u_tick
    (
        .i_clock    (i_clock),
        .i_srst     (i_srst),
        .i_wr_lo    (wr_ok && (i_spr_num == SPR_TICK_LW)),
        .i_wr_hi    (wr_ok && (i_spr_num == SPR_TICK_HW)),
        .i_wr_cd    (wr_ok && (i_spr_num == SPR_CDOWN)),
        .i_wdata    (i_spr_wdata),
        .i_cd_taken (i_exc_take && i_exc_is_cd),
        .o_tick     (tick),
        .o_cdown    (cdown),
        .o_cd_pend  (cd_pend)
    );

    // --------------------------------------------------------------
    // Machine state word
    // --------------------------------------------------------------

    // Exception entry outranks a return, which outranks a direct write.
    // The vector pick is strapped at reset; all other bits start clear.
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            msw_q             <= MSW_RESET;
            msw_q[B_VEC_HIGH] <= i_vec_strap;
        end
        else if (i_exc_take)
        begin
            msw_q               <= msw_q & ~MSW_EXC_CLR;
            msw_q[B_ORDER_NORM] <= msw_q[B_ORDER_TRAP];
        end
        else if (i_rfi)
            msw_q <= {msw_q[31:16], saved_q[15:0]} & MSW_WR_MASK;
        else if (i_msw_wr && !user_mode)
            msw_q <= i_msw_wdata & MSW_WR_MASK;
    end

    assign o_msw = msw_q;

    sstd_msw_decode u_decode
    (
        .i_msw (msw_q),
        .o_ctl (o_ctl)
    );

    // --------------------------------------------------------------
    // Save/restore pair
    // --------------------------------------------------------------

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            ret_adr_q <= 32'h0000_0000;
        else if (i_exc_take)
            ret_adr_q <= i_exc.resume;
        else if (wr_ok && (i_spr_num == SPR_RET_ADR))
            ret_adr_q <= i_spr_wdata;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            saved_q <= 32'h0000_0000;
        else if (i_exc_take)
            saved_q <= {i_exc.info, msw_q[15:0]};
        else if (wr_ok && (i_spr_num == SPR_SAVED))
            saved_q <= i_spr_wdata;
    end

    assign o_resume_pc = ret_adr_q;

    // --------------------------------------------------------------
    // Fault reason and address
    // --------------------------------------------------------------

    // No reset: software may inspect these after a restart.
    always_ff @(posedge i_clock)
    begin
        if (i_align_fault || i_data_fault)
            flt_rsn_q <= i_fault_reason;
        else if (wr_ok && (i_spr_num == SPR_FLT_RSN))
            flt_rsn_q <= i_spr_wdata;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_align_fault)
            flt_adr_q <= i_fault_addr;
        else if (wr_ok && (i_spr_num == SPR_FLT_ADR))
            flt_adr_q <= i_spr_wdata;
    end

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------

    // Reads only sample; the countdown and its latch see no strobe here.
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            rdata_q <= 32'h0000_0000;
        else if (rd_ok)
        begin
            case (i_spr_num)
                SPR_FLT_RSN: rdata_q <= flt_rsn_q;
                SPR_FLT_ADR: rdata_q <= flt_adr_q;
                SPR_CDOWN:   rdata_q <= cdown;
                SPR_RET_ADR: rdata_q <= ret_adr_q;
                SPR_SAVED:   rdata_q <= saved_q;
                SPR_TICK_LR: rdata_q <= tick[31:0];
                SPR_TICK_HR: rdata_q <= tick[63:32];
                default:     rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign o_spr_rdata = rdata_q;

    // --------------------------------------------------------------
    // Requests and refusals
    // --------------------------------------------------------------

    assign o_ext_req     = i_ext_irq && msw_q[B_EXT_IRQ];
    assign o_cd_req      = cd_pend && msw_q[B_EXT_IRQ];
    assign o_mcheck_req  = i_mcheck && msw_q[B_MCHECK_ON];
    assign o_fp_refuse   = i_fp_instr && !msw_q[B_FLOAT_ON];
    assign o_priv_refuse = i_sup_instr && user_mode;
    assign o_recoverable = msw_q[B_CAN_RESUME];

    // Step trace fires only on a completion that raised nothing else.
    assign o_trace_req = (msw_q[B_STEP_TRACE] && i_instr_done && !i_instr_exc)
                       || (msw_q[B_BR_TRACE] && i_branch_done);

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------

    a_trap_order_copy:
        assert property (@(posedge i_clock) disable iff (i_srst)
            i_exc_take |=> (msw_q[B_ORDER_NORM] == $past(msw_q[B_ORDER_TRAP])))
        else $error("trap byte order not copied on exception");

    a_cd_req_gate:
        assert property (@(posedge i_clock) disable iff (i_srst)
            !o_msw[B_EXT_IRQ] |-> (!o_cd_req && !o_ext_req))
        else $error("countdown request passed while disabled");

    a_user_priv:
        assert property (@(posedge i_clock) disable iff (i_srst)
            (i_sup_instr && msw_q[B_USER_ONLY]) |-> o_priv_refuse)
        else $error("supervisor instruction allowed at user level");

    a_fp_refuse:
        assert property (@(posedge i_clock) disable iff (i_srst)
            i_fp_instr |-> (o_fp_refuse == !o_ctl.float_unit_on))
        else $error("float refusal disagrees with state word");

    a_mcheck_gate:
        assert property (@(posedge i_clock) disable iff (i_srst)
            o_mcheck_req |-> (i_mcheck && o_ctl.machine_check_on))
        else $error("machine check taken while disabled");

    a_vec_base:
        assert property (@(posedge i_clock) disable iff (i_srst)
            o_ctl.vector_base == (msw_q[B_VEC_HIGH] ? 32'hfff0_0000 : 32'h0))
        else $error("vector base wrong");

    a_tick_guard:
        assert property (@(posedge i_clock) disable iff (i_srst)
            (i_spr_wr && user_mode && (i_spr_num == SPR_TICK_LW))
            |=> (tick[31:0] == $past(tick[31:0]) + 32'h1
                 || tick[31:0] == $past(tick[31:0])))
        else $error("user write reached tick counter");

    a_cd_read_quiet:
        assert property (@(posedge i_clock) disable iff (i_srst)
            (rd_ok && (i_spr_num == SPR_CDOWN)) |=> (rdata_q == $past(cdown)))
        else $error("countdown read returned wrong value");

    a_fault_addr:
        assert property (@(posedge i_clock)
            i_align_fault |=> (flt_adr_q == $past(i_fault_addr)))
        else $error("fault address not captured");

    a_exc_save:
        assert property (@(posedge i_clock) disable iff (i_srst)
            i_exc_take |=> (saved_q == {$past(i_exc.info), $past(msw_q[15:0])})
                        && (ret_adr_q == $past(i_exc.resume)))
        else $error("save pair not loaded on exception");

    a_rfi_restore:
        assert property (@(posedge i_clock) disable iff (i_srst)
            (i_rfi && !i_exc_take)
            |=> (msw_q[15:0] == ($past(saved_q[15:0]) & MSW_WR_MASK[15:0])))
        else $error("return did not restore state word");

endmodule
`default_nettype wire

// File: verif/sstd_supervisor_tb_top.sv
/*
 * Self-checking bench for the supervisor state and countdown block.
 * Assumes the designer's divider of 2 and a 200 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module sstd_supervisor_top_tb_top;
    import sstd_pkg::*;
    logic        clk = 0, srst = 1, strap = 1, wr = 0, rd = 0, mw = 0, tk = 0;
    logic        iscd = 0, rfi = 0, af = 0, df = 0, xirq = 0, mc = 0, idn = 0;
    logic        iex = 0, bdn = 0, fpi = 0, supi = 0;
    logic [9:0]  num = 10'h000;
    logic [31:0] wd = 32'h0, mwd = 32'h0, frs = 32'h0, fad = 32'h0, rdat, msw, rpc;
    sstd_exc_t   exc = '0;
    sstd_ctl_t   ctl;
    logic        refd, xr, cdr, mcr, trr, fpr, prr, rec;
    int          n_errors = 0, cmp_count = 0, cyc = 0;

    sstd_supervisor_top #(.CD_DIV(2)) i_dut (.i_clock(clk), .i_srst(srst),
        .i_vec_strap(strap), .i_spr_wr(wr), .i_spr_rd(rd), .i_spr_num(num),
        .i_spr_wdata(wd), .o_spr_rdata(rdat), .o_spr_refused(refd), .i_msw_wr(mw),
        .i_msw_wdata(mwd), .o_msw(msw), .i_exc_take(tk), .i_exc(exc),
        .i_exc_is_cd(iscd), .i_rfi(rfi), .o_resume_pc(rpc), .i_align_fault(af),
        .i_data_fault(df), .i_fault_reason(frs), .i_fault_addr(fad),
        .i_ext_irq(xirq), .i_mcheck(mc), .i_instr_done(idn), .i_instr_exc(iex),
        .i_branch_done(bdn), .i_fp_instr(fpi), .i_sup_instr(supi), .o_ctl(ctl),
        .o_ext_req(xr), .o_cd_req(cdr), .o_mcheck_req(mcr), .o_trace_req(trr),
        .o_fp_refuse(fpr), .o_priv_refuse(prr), .o_recoverable(rec));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial forever #2.5 clk = ~clk;

    // The whole sequence needs about 70 cycles; this ceiling catches a hang.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One move cycle; the refusal flag is judged while the request is held.
    task automatic spr(input logic w, input logic [9:0] n, input logic [31:0] d,
                       input logic rf);
        @(negedge clk);
        wr = w;
        rd = !w;
        num = n;
        wd = d;
        #1 chk(32'(refd), 32'(rf));
        @(negedge clk);
        wr = 0;
        rd = 0;
    endtask

    task automatic msw_w(input logic [31:0] d);
        @(negedge clk);
        mw = 1;
        mwd = d;
        @(negedge clk);
        mw = 0;
    endtask

    task automatic take(input logic [15:0] inf, input logic [31:0] pc, input logic cd);
        @(negedge clk);
        tk = 1;
        iscd = cd;
        exc = '{info: inf, resume: pc};
        @(negedge clk);
        tk = 0;
        iscd = 0;
    endtask

    task automatic ret();
        @(negedge clk);
        rfi = 1;
        @(negedge clk);
        rfi = 0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_state();
        chk(ctl.vector_base, VEC_BASE_HI);
        msw_w(32'h0);
        chk(ctl.vector_base, VEC_BASE_LO);
        msw_w(32'hffff_ffff);
        chk(msw, MSW_WR_MASK);
        @(negedge clk);
        {xirq, mc, fpi, supi, idn, iex} = 6'h3f;
        #1 chk(32'({xr, mcr, fpr, prr, rec, trr, ctl.little_endian, ctl.float_precise}),
               32'h0db);
        @(negedge clk);
        bdn = 1;
        #1 chk(32'(trr), 32'h1);
        @(negedge clk);
        {bdn, iex} = 2'b00;
        #1 chk(32'(trr), 32'h1);
        spr(1, SPR_TICK_LW, 32'h5, 1);
    endtask

    task automatic t_exc();
        take(16'ha5a5, 32'h1234_5678, 0);
        chk(msw, (MSW_WR_MASK & ~MSW_EXC_CLR) | 32'h1);
        chk(32'({xr, mcr, fpr, prr, rec, trr, ctl.little_endian, ctl.float_precise}),
            32'h62);
        chk(rpc, 32'h1234_5678);
        spr(0, SPR_SAVED, 32'h0, 0);
        chk(rdat, {16'ha5a5, MSW_WR_MASK[15:0]});
        ret();
        chk(msw, MSW_WR_MASK);
        {xirq, mc, fpi, supi, idn, iex, bdn} = 7'h0;
        take(16'h0, 32'h0, 0);
        msw_w(32'h0000_8000);
    endtask

    task automatic t_tick_fault();
        spr(1, SPR_TICK_HW, 32'hdead_0000, 0);
        spr(1, SPR_TICK_LW, 32'h10, 0);
        spr(0, SPR_TICK_HR, 32'h0, 0);
        chk(rdat, 32'hdead_0000);
        spr(0, SPR_TICK_LR, 32'h0, 0);
        chk(rdat & 32'hffff_fff0, 32'h10);
        spr(0, SPR_TICK_HW, 32'h0, 1);
        spr(0, 10'h3ff, 32'h0, 1);
        @(negedge clk);
        {af, frs, fad} = {1'b1, 32'hc0de_0001, 32'h0000_1003};
        @(negedge clk);
        {af, df, frs} = {2'b01, 32'h2};
        @(negedge clk);
        df = 0;
        srst = 1;
        @(negedge clk);
        srst = 0;
        chk(msw, 32'h0000_0040);
        spr(0, SPR_FLT_RSN, 32'h0, 0);
        chk(rdat, 32'h2);
        spr(0, SPR_FLT_ADR, 32'h0, 0);
        chk(rdat, 32'h0000_1003);
        msw_w(32'h0000_8000);
    endtask

    task automatic t_cdown();
        chk(32'(cdr), 32'h1);
        spr(1, SPR_CDOWN, 32'h7fff_ff80, 0);
        spr(0, SPR_CDOWN, 32'h0, 0);
        chk(rdat & 32'hffff_ff00, 32'h7fff_ff00);
        spr(0, SPR_CDOWN, 32'h0, 0);
        chk(32'(cdr), 32'h1);
        take(16'h0, 32'h0, 1);
        ret();
        chk(32'(cdr), 32'h0);
        spr(1, SPR_CDOWN, 32'h8000_0000, 0);
        chk(32'(cdr), 32'h1);
    endtask

    initial
    begin
        repeat (16) @(negedge clk);
        srst = 0;
        @(negedge clk);
        chk(msw, 32'h0000_0040);
        t_state();
        t_exc();
        t_tick_fault();
        t_cdown();
        final_report();
    end
endmodule

`default_nettype wire
